// ===== logic/gsc_params.svh
/*
   Constants of the gated sampling controller: register offsets, field
   positions, reset values and the fixed start-delay and length tables.
   Assumes it is included by its bare name from the package and the top.
*/
// Operation
// - gated: store only while gate condition holds
// - standard mode stops at total count immediately
// - no pretrigger; segment length ignored when gated
// - FIFO mode: same setup, no total limit
// - only twelve listed gate modes are accepted
// - one channel start offsets per rate, source
// - two channel start offsets per source at fast rate; slow rate uses the one channel slow offsets
// - start delay fixed; negative shows gate event
// - pipeline compensates delay during acquisition
// - one channel stores 7/12 fewer samples
// - two channels store 3/6 fewer samples
// - gate end acted on at eight-sample boundary
// - boundary counted over all active channels
// - up to seven extra samples after gate end
// - external edge gate opens/closes on edges
// - external width gate opens after held width
// - channel level gate opens/closes on crossings
// - channel width gate opens after held width
// - window gates open on entry or exit
// - window entry width gate: slow entry opens
// - window exit width gate: slow exit opens
`ifndef GSC_PARAMS_SVH
`define GSC_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define GSC_ADR_CTRL      8'h00
`define GSC_ADR_CONFIG    8'h04
`define GSC_ADR_LEVEL     8'h08
`define GSC_ADR_WIDTH     8'h0C
`define GSC_ADR_TOTAL     8'h10
`define GSC_ADR_SEGLEN    8'h14
`define GSC_ADR_STATUS    8'h18
`define GSC_ADR_COUNT     8'h1C

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define GSC_CTRL_GATE_EN  0
`define GSC_CTRL_FIFO     1
`define GSC_CTRL_START    2
`define GSC_CTRL_STOP     3
`define GSC_CFG_SYNC      4
`define GSC_CFG_TWO_CH    5
`define GSC_CFG_FAST      6
`define GSC_CFG_CH_SEL    7
`define GSC_LEVEL_LOW_LSB 16
`define GSC_RST_TOTAL     32'h0000_1000
`define GSC_RST_LEVEL     32'h0400_0C00

// ----------------------------------------------------------------------
// start offsets in samples, order ext, int, ext sync, int sync
// ----------------------------------------------------------------------
`define GSC_PIPE_COMP     11
`define GSC_OFS_1S_EXT    (-11)
`define GSC_OFS_1S_INT    3
`define GSC_OFS_1S_EXTS   (-10)
`define GSC_OFS_1S_INTS   4
`define GSC_OFS_1F_EXT    2
`define GSC_OFS_1F_INT    16
`define GSC_OFS_1F_EXTS   3
`define GSC_OFS_1F_INTS   17
`define GSC_OFS_2F_EXT    (-5)
`define GSC_OFS_2F_INT    8
`define GSC_OFS_2F_EXTS   (-4)
`define GSC_OFS_2F_INTS   9

// ----------------------------------------------------------------------
// samples lost per gate and alignment
// ----------------------------------------------------------------------
`define GSC_LESS_1S       7
`define GSC_LESS_1F       12
`define GSC_LESS_2S       3
`define GSC_LESS_2F       6

`endif

// ===== logic/gsc_pkg.sv
/*
   Types of the gated sampling controller.
   Assumes the constants header sits beside it.
*/
package gsc_pkg;
   `include "gsc_params.svh"

   // gate condition codes, in register order
   typedef enum logic [3:0] {
      EXT_RISING_GATE, EXT_FALLING_GATE, EXT_HIGH_WIDTH_GATE, EXT_LOW_WIDTH_GATE,
      CHAN_RISING_LEVEL_GATE, CHAN_FALLING_LEVEL_GATE, CHAN_ABOVE_WIDTH_GATE,
      CHAN_BELOW_WIDTH_GATE, CHAN_WINDOW_ENTRY_GATE, CHAN_WINDOW_ENTRY_WIDTH_GATE,
      CHAN_WINDOW_EXIT_GATE, CHAN_WINDOW_EXIT_WIDTH_GATE
   } gsc_mode_t;

   // acquisition sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_DELAY, ST_STORE, ST_DONE} gsc_state_t;
endpackage

// ===== logic/gsc_top.sv
/*
   Gated sampling controller: wishbone register file, gate condition
   detection, fixed start delay, end-of-gate alignment and memory write.
   Assumes sample strobe and channel data come from logic on the same
   clock; the external trigger is an asynchronous pin.
*/
`timescale 1ns/100ps
`include "gsc_params.svh"

module gsc_top
   import gsc_pkg::*;
#(
   parameter int PIPE_DEPTH = `GSC_PIPE_COMP
) (
   // system
   input  wire logic        clock,
   input  wire logic        reset,
   // wishbone slave
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [7:0]  wbAdr,
   input  wire logic [3:0]  wbSel,
   input  wire logic [31:0] wbDatW,
   output logic      [31:0] wbDatR,
   output logic             wbAck,
   // sampling front end
   input  wire logic        sampleValid,
   input  wire logic [11:0] ch0Data,
   input  wire logic [11:0] ch1Data,
   input  wire logic        extTrigger,
   // memory write side
   output logic             memWrite,
   output logic      [23:0] memData,
   output logic             acqBusy
);

   // ---------------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------------
   logic [31:0]                  ctrlReg, ctrlNext;
   logic [31:0]                  configReg, configNext;
   logic [31:0]                  levelReg, levelNext;
   logic [31:0]                  widthReg, widthNext;
   logic [31:0]                  totalReg, totalNext;
   logic [31:0]                  segLenReg, segLenNext;
   logic [31:0]                  datRReg, datRNext;
   logic                         ackReg, ackNext;
   logic                         startPulse, stopPulse;
   logic                         extSync1Reg, extSync2Reg;

   // data pipeline: compensation depth plus the longest lost-sample stretch
   localparam int                DLY_DEPTH = PIPE_DEPTH + `GSC_LESS_1F;
   gsc_state_t                   stateReg, stateNext;
   logic [DLY_DEPTH-1:0][23:0]   dlyReg, dlyNext;
   logic                         prevReg, prevNext;
   logic [15:0]                  heldReg, heldNext;
   logic [5:0]                   waitCntReg, waitCntNext;
   logic [16:0]                  gateLenReg, gateLenNext;
   logic [16:0]                  storedReg, storedNext;
   logic signed [17:0]           permitReg, permitNext;
   logic                         closedReg, closedNext;
   logic [31:0]                  countReg, countNext;
   logic [2:0]                   alignReg, alignNext;
   logic                         modeErrReg, modeErrNext;
   logic                         memWriteReg, memWriteNext;
   logic [23:0]                  memDataReg, memDataNext;
   logic                         busyReg, busyNext;

   // configuration fields
   logic                         gateEn, fifoMode, syncOn, twoCh, fastRate, chSel;
   logic [3:0]                   modeCode;
   logic [11:0]                  levelUp, levelLow;
   logic                         modeValid;
   logic [5:0]                   startWait;
   logic [4:0]                   lessCnt;

   assign gateEn   = ctrlReg[`GSC_CTRL_GATE_EN];
   assign fifoMode = ctrlReg[`GSC_CTRL_FIFO];
   assign modeCode = configReg[3:0];
   assign syncOn   = configReg[`GSC_CFG_SYNC];
   assign twoCh    = configReg[`GSC_CFG_TWO_CH];
   assign fastRate = configReg[`GSC_CFG_FAST];
   assign chSel    = configReg[`GSC_CFG_CH_SEL];
   assign levelUp  = levelReg[11:0];
   assign levelLow = levelReg[`GSC_LEVEL_LOW_LSB+11:`GSC_LEVEL_LOW_LSB];

   // ---------------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------------

   // byte-lane merge of a write
   function automatic logic [31:0] mergeWord(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0]  sel);
      logic [31:0] res;
      res = oldVal;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = newVal[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // start wait in samples: offset plus pipeline compensation
   function automatic logic [5:0] calcWait(input logic two, input logic fast,
                                           input logic intSrc, input logic sync);
      int ofs;
      ofs = 0;
      case ({two, fast, sync, intSrc})
         4'h0, 4'h8 : ofs = `GSC_OFS_1S_EXT;
         4'h1, 4'h9 : ofs = `GSC_OFS_1S_INT;
         4'h2, 4'hA : ofs = `GSC_OFS_1S_EXTS;
         4'h3, 4'hB : ofs = `GSC_OFS_1S_INTS;
         4'h4       : ofs = `GSC_OFS_1F_EXT;
         4'h5       : ofs = `GSC_OFS_1F_INT;
         4'h6       : ofs = `GSC_OFS_1F_EXTS;
         4'h7       : ofs = `GSC_OFS_1F_INTS;
         4'hC       : ofs = `GSC_OFS_2F_EXT;
         4'hD       : ofs = `GSC_OFS_2F_INT;
         4'hE       : ofs = `GSC_OFS_2F_EXTS;
         default    : ofs = `GSC_OFS_2F_INTS;
      endcase
      return 6'(ofs + PIPE_DEPTH);
   endfunction

   assign modeValid = (modeCode <= 4'(CHAN_WINDOW_EXIT_WIDTH_GATE));
   // fixed start wait, stretched by the lost samples
   assign startWait = calcWait(twoCh, fastRate, (modeCode >= 4'(CHAN_RISING_LEVEL_GATE)), syncOn) + 6'(lessCnt);
   assign lessCnt = twoCh ? (fastRate ? 5'(`GSC_LESS_2F) : 5'(`GSC_LESS_2S))
                          : (fastRate ? 5'(`GSC_LESS_1F) : 5'(`GSC_LESS_1S));

   // ---------------------------------------------------------------------
   // wishbone slave
   // ---------------------------------------------------------------------

   // one wait cycle; writes land on the edge that sees ack high
   always_comb begin
      logic wrNow;
      wrNow      = wbCyc && wbStb && wbWe && ackReg;
      ackNext    = wbCyc && wbStb && !ackReg;
      ctrlNext   = ctrlReg & ~(32'h1 << `GSC_CTRL_START) & ~(32'h1 << `GSC_CTRL_STOP);
      configNext = configReg;
      levelNext  = levelReg;
      widthNext  = widthReg;
      totalNext  = totalReg;
      segLenNext = segLenReg;
      if (wrNow) begin
         if (wbAdr == `GSC_ADR_CTRL) begin
            ctrlNext = mergeWord(32'h0, wbDatW & 32'h0000_000F, wbSel) |
                       (ctrlReg & ~{24'h0, {8{wbSel[0]}}} & 32'h0000_0003);
         end else if (wbAdr == `GSC_ADR_CONFIG) begin
            configNext = mergeWord(configReg, wbDatW & 32'h0000_00FF, wbSel);
         end else if (wbAdr == `GSC_ADR_LEVEL) begin
            levelNext = mergeWord(levelReg, wbDatW & 32'h0FFF_0FFF, wbSel);
         end else if (wbAdr == `GSC_ADR_WIDTH) begin
            widthNext = mergeWord(widthReg, wbDatW & 32'h0000_FFFF, wbSel);
         end else if (wbAdr == `GSC_ADR_TOTAL) begin
            totalNext = mergeWord(totalReg, wbDatW, wbSel);
         end else if (wbAdr == `GSC_ADR_SEGLEN) begin
            segLenNext = mergeWord(segLenReg, wbDatW, wbSel);
         end
      end
      datRNext = datRReg;
      if (wbCyc && wbStb && !ackReg) begin
         if (wbAdr == `GSC_ADR_CTRL) begin
            datRNext = {30'h0, ctrlReg[1:0]};
         end else if (wbAdr == `GSC_ADR_CONFIG) begin
            datRNext = configReg;
         end else if (wbAdr == `GSC_ADR_LEVEL) begin
            datRNext = levelReg;
         end else if (wbAdr == `GSC_ADR_WIDTH) begin
            datRNext = widthReg;
         end else if (wbAdr == `GSC_ADR_TOTAL) begin
            datRNext = totalReg;
         end else if (wbAdr == `GSC_ADR_SEGLEN) begin
            datRNext = segLenReg;
         end else if (wbAdr == `GSC_ADR_STATUS) begin
            datRNext = {26'h0, modeErrReg, (stateReg == ST_DONE),
                        (((stateReg == ST_DELAY) || (stateReg == ST_STORE)) && !closedReg),
                        busyReg, 2'h0};
         end else if (wbAdr == `GSC_ADR_COUNT) begin
            datRNext = countReg;
         end else begin
            datRNext = 32'h0;
         end
      end
   end

   assign startPulse = ctrlReg[`GSC_CTRL_START];
   assign stopPulse  = ctrlReg[`GSC_CTRL_STOP];

   // bus registers
   always_ff @(posedge clock) begin
      if (reset) begin
         ackReg    <= 1'b0;
         datRReg   <= 32'h0;
         ctrlReg   <= 32'h0;
         configReg <= 32'h0;
         levelReg  <= `GSC_RST_LEVEL;
         widthReg  <= 32'h0;
         totalReg  <= `GSC_RST_TOTAL;
         segLenReg <= 32'h0;
      end else begin
         ackReg    <= ackNext;
         datRReg   <= datRNext;
         ctrlReg   <= ctrlNext;
         configReg <= configNext;
         levelReg  <= levelNext;
         widthReg  <= widthNext;
         totalReg  <= totalNext;
         segLenReg <= segLenNext;
      end
   end

   // ---------------------------------------------------------------------
   // gate condition
   // ---------------------------------------------------------------------

   // trigger pin synchroniser
   always_ff @(posedge clock) begin
      if (reset) begin
         extSync1Reg <= 1'b0;
         extSync2Reg <= 1'b0;
      end else begin
         extSync1Reg <= extTrigger;
         extSync2Reg <= extSync1Reg;
      end
   end

   logic        condLevel, useWidth, openEvt, closeEvt;
   logic [11:0] chData;
   logic        above, below, inWin;

   // condition level per mode; open on rise or held width, close on fall
   always_comb begin
      chData = chSel ? ch1Data : ch0Data;
      above  = chData > levelUp;
      below  = chData < levelUp;
      inWin  = (chData > levelLow) && (chData < levelUp);
      condLevel = 1'b0;
      useWidth  = 1'b0;
      case (gsc_mode_t'(modeCode))
         EXT_RISING_GATE              : condLevel = extSync2Reg;
         EXT_FALLING_GATE             : condLevel = !extSync2Reg;
         EXT_HIGH_WIDTH_GATE          : begin condLevel = extSync2Reg;  useWidth = 1'b1; end
         EXT_LOW_WIDTH_GATE           : begin condLevel = !extSync2Reg; useWidth = 1'b1; end
         CHAN_RISING_LEVEL_GATE       : condLevel = above;
         CHAN_FALLING_LEVEL_GATE      : condLevel = below;
         CHAN_ABOVE_WIDTH_GATE        : begin condLevel = above; useWidth = 1'b1; end
         CHAN_BELOW_WIDTH_GATE        : begin condLevel = below; useWidth = 1'b1; end
         CHAN_WINDOW_ENTRY_GATE       : condLevel = inWin;
         CHAN_WINDOW_EXIT_GATE        : condLevel = !inWin;
         CHAN_WINDOW_ENTRY_WIDTH_GATE : begin condLevel = inWin; useWidth = 1'b1; end
         CHAN_WINDOW_EXIT_WIDTH_GATE  : begin condLevel = !inWin; useWidth = 1'b1; end
         default                      : condLevel = 1'b0;
      endcase
      heldNext = condLevel ? ((heldReg == 16'hFFFF) ? heldReg : heldReg + 16'h1) : 16'h0;
      openEvt  = useWidth ? (condLevel && (heldNext == widthReg[15:0] + 16'h1))
                          : (condLevel && !prevReg);
      closeEvt = !condLevel && prevReg;
   end

   // ---------------------------------------------------------------------
   // acquisition sequencer
   // ---------------------------------------------------------------------
   always_comb begin
      logic doTry;
      logic doStore;
      doTry        = 1'b0;
      doStore      = 1'b0;
      stateNext    = stateReg;
      dlyNext      = dlyReg;
      prevNext     = prevReg;
      waitCntNext  = waitCntReg;
      gateLenNext  = gateLenReg;
      storedNext   = storedReg;
      permitNext   = permitReg;
      closedNext   = closedReg;
      countNext    = countReg;
      alignNext    = alignReg;
      modeErrNext  = modeErrReg;
      memWriteNext = 1'b0;
      memDataNext  = memDataReg;
      if (stopPulse) begin
         stateNext = ST_IDLE;
      end else if (startPulse) begin
         // no pretrigger: nothing stored before the first gate
         modeErrNext = gateEn && !modeValid;
         stateNext   = (gateEn && !modeValid) ? ST_IDLE : (gateEn ? ST_ARMED : ST_STORE);
         prevNext    = 1'b1;
         closedNext  = 1'b0;
         storedNext  = 17'h0;
         countNext   = 32'h0;
         alignNext   = 3'h0;
      end else if (sampleValid) begin
         // data pipeline compensates the start delay
         dlyNext  = {dlyReg[DLY_DEPTH-2:0], ch1Data, ch0Data};
         prevNext = condLevel;
         // gate length and close tracking inside a gate
         if (((stateReg == ST_DELAY) || (stateReg == ST_STORE)) && gateEn && !closedReg) begin
            if (closeEvt) begin
               closedNext = 1'b1;
               permitNext = $signed({1'b0, gateLenReg}) - $signed({13'h0, lessCnt});
            end else begin
               gateLenNext = gateLenReg + 17'h1;
            end
         end
         case (stateReg)
            ST_ARMED : begin
               // wait for the gate to open
               if (openEvt) begin
                  closedNext  = 1'b0;
                  storedNext  = 17'h0;
                  gateLenNext = 17'h1;
                  if (startWait == 6'h0) begin
                     stateNext = ST_STORE;
                     doTry     = 1'b1;
                  end else begin
                     stateNext   = ST_DELAY;
                     waitCntNext = 6'h1;
                  end
               end
            end
            ST_DELAY : begin
               // constant wait before the first stored sample
               if (closedNext && ($signed({1'b0, storedReg}) >= permitNext)) begin
                  stateNext = ST_ARMED;
               end else if (waitCntReg == startWait) begin
                  stateNext = ST_STORE;
                  doTry     = 1'b1;
               end else begin
                  waitCntNext = waitCntReg + 6'h1;
               end
            end
            ST_STORE : doTry = 1'b1;
            default  : doTry = 1'b0;
         endcase
         if (doTry) begin
            // total limit in standard mode only
            if (!fifoMode && (countReg == totalReg)) begin
               stateNext = ST_DONE;
            // pause only on the alignment boundary
            end else if (gateEn && closedNext && (alignReg == 3'h0) &&
                         ($signed({1'b0, storedReg}) >= permitNext)) begin
               stateNext = ST_ARMED;
            end else begin
               doStore = 1'b1;
            end
         end
         if (doStore) begin
            memWriteNext = 1'b1;
            // deeper tap keeps the data offset despite the later first store
            memDataNext  = dlyReg[PIPE_DEPTH-1+int'(lessCnt)];
            countNext    = countReg + 32'h1;
            storedNext   = storedReg + 17'h1;
            alignNext    = alignReg + (twoCh ? 3'h2 : 3'h1);
         end
      end
      busyNext = (stateNext != ST_IDLE) && (stateNext != ST_DONE);
   end

   // sequencer registers
   always_ff @(posedge clock) begin
      if (reset) begin
         stateReg    <= ST_IDLE;
         dlyReg      <= '0;
         prevReg     <= 1'b1;
         heldReg     <= 16'h0;
         waitCntReg  <= 6'h0;
         gateLenReg  <= 17'h0;
         storedReg   <= 17'h0;
         permitReg   <= 18'sh0;
         closedReg   <= 1'b0;
         countReg    <= 32'h0;
         alignReg    <= 3'h0;
         modeErrReg  <= 1'b0;
         memWriteReg <= 1'b0;
         memDataReg  <= 24'h0;
         busyReg     <= 1'b0;
      end else begin
         stateReg    <= stateNext;
         dlyReg      <= dlyNext;
         prevReg     <= prevNext;
         heldReg     <= (startPulse || !sampleValid) ? (startPulse ? 16'h0 : heldReg) : heldNext;
         waitCntReg  <= waitCntNext;
         gateLenReg  <= gateLenNext;
         storedReg   <= storedNext;
         permitReg   <= permitNext;
         closedReg   <= closedNext;
         countReg    <= countNext;
         alignReg    <= alignNext;
         modeErrReg  <= modeErrNext;
         memWriteReg <= memWriteNext;
         memDataReg  <= memDataNext;
         busyReg     <= busyNext;
      end
   end

   // outputs straight from flip-flops
   assign wbAck    = ackReg;
   assign wbDatR   = datRReg;
   assign memWrite = memWriteReg;
   assign memData  = memDataReg;
   assign acqBusy  = busyReg;

endmodule // gsc_top

// ===== tb/gsc_gate_src.sv
/* model of the gate source and sampling front end of gsc_top.
   assumes one clock; the bench sets gateReq just after a sample edge */
`timescale 1ns/100ps
module gsc_gate_src (
   // system
   input  wire logic        clock,
   input  wire logic        reset,
   // gate request from the bench
   input  wire logic        gateReq,
   // front end
   output logic             sampleValid,
   output logic      [11:0] ch0Data,
   output logic      [11:0] ch1Data,
   output logic             extTrigger
);
   logic [1:0]  phase_reg = 2'h0;
   logic        pulse_reg = 1'b0;
   logic [11:0] ramp_reg  = 12'h000;
   // one sample every four clocks, ramp data
   always_ff @(posedge clock) begin
      phase_reg <= reset ? 2'h0 : phase_reg + 2'h1;
      pulse_reg <= (phase_reg == 2'h3);
      if (phase_reg == 2'h3) ramp_reg <= ramp_reg + 12'h001;
   end
   assign sampleValid = pulse_reg;
   assign ch0Data     = ramp_reg;
   assign ch1Data     = ~ramp_reg;
   assign extTrigger  = gateReq; // gate level on the trigger pin
endmodule // gsc_gate_src

// ===== tb/gsc_properties.sv
/* checker of bus answer and store timing of gsc_top.
   assumes it is bound to the ports of gsc_top */
`timescale 1ns/100ps
module gsc_properties (
   // watched ports
   input wire logic        clock,
   input wire logic        reset,
   input wire logic        wbCyc,
   input wire logic        wbStb,
   input wire logic        wbAck,
   input wire logic        sampleValid,
   input wire logic        memWrite,
   input wire logic [23:0] memData,
   input wire logic        acqBusy
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // bus answers once per request
   AST_ACK_ANSWER: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
      else $error("no ack after request");
   AST_ACK_ONE: assert property (wbAck |=> !wbAck)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (wbAck |-> $past(wbCyc && wbStb))
      else $error("ack without request");
   // stores follow samples of a running acquisition
   AST_WR_CAUSE: assert property (memWrite |-> $past(sampleValid))
      else $error("store without sample");
   AST_IDLE_QUIET: assert property (!acqBusy [*3] |=> !memWrite)
      else $error("store while idle");
   AST_DATA_HOLD: assert property (!memWrite |-> $stable(memData))
      else $error("store data moved");
   AST_BUSY_ROSE: assert property ($rose(acqBusy) |-> !memWrite)
      else $error("store at start");
   AST_START_ACK: assert property ($rose(acqBusy) |-> $past(wbAck) || $past(wbAck, 2))
      else $error("start without write");
endmodule // gsc_properties
bind gsc_top gsc_properties u_prop (.clock, .reset, .wbCyc, .wbStb, .wbAck,
   .sampleValid, .memWrite, .memData, .acqBusy);

// ===== tb/tb_gsc_top.sv
/* bench of gsc_top: wishbone tasks and gated runs.
   assumes gsc_gate_src drives samples and the trigger pin */
`timescale 1ns/100ps
module tb_gsc_top;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, gateReq = 1'b0;
   logic [7:0]  wbAdr = 8'h00;
   logic [3:0]  wbSel = 4'hF;
   logic [31:0] wbDatW = 32'h0, wbDatR, rd;
   logic        wbAck, sampleValid, extTrigger, memWrite, acqBusy;
   logic [11:0] ch0Data, ch1Data, gateAt;
   logic [23:0] memData, firstData;
   int          nWr = 0, error_cnt = 0, n_checks = 0, cyc = 0;

   gsc_top dut (.clock, .reset, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW,
      .wbDatR, .wbAck, .sampleValid, .ch0Data, .ch1Data, .extTrigger,
      .memWrite, .memData, .acqBusy);
   gsc_gate_src src (.clock, .reset, .gateReq, .sampleValid, .ch0Data,
      .ch1Data, .extTrigger);

   initial forever #50 clock = ~clock;
   // one classic cycle, held until ack
   task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= a;
      wbDatW <= d;
      @(posedge clock iff wbAck === 1'b1);
      rd = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      wbXfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // gate open for len samples, then settle
   task automatic gate(input int len);
      // skip the start edge, whose sample the design ignores
      @(posedge clock);
      @(posedge clock iff sampleValid === 1'b1);
      gateAt = ch0Data;
      gateReq <= 1'b1;
      repeat (len) @(posedge clock iff sampleValid === 1'b1);
      gateReq <= 1'b0;
      repeat (200) @(posedge clock);
   endtask
   task automatic summarize;
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // count stores, keep the first one
   always @(posedge clock) begin
      if (memWrite === 1'b1) begin
         if (nWr == 0) firstData = memData;
         nWr++;
      end
   end
   // hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      // reset values, unmapped and read-only places
      rdChk(8'h10, 32'h0000_1000);
      rdChk(8'h08, 32'h0400_0C00);
      rdChk(8'h20, 32'h0);
      wbXfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
      rdChk(8'h1C, 32'h0);
      $display("registers done");
      // ungated standard run stops at total
      wbXfer(1'b1, 8'h10, 32'h14);
      nWr = 0;
      wbXfer(1'b1, 8'h00, 32'h04);
      repeat (2) @(posedge clock);
      wait (acqBusy === 1'b0);
      chk(nWr, 32'h14);
      rdChk(8'h1C, 32'h14);
      $display("standard done");
      // fifo run ignores total until stopped
      wbXfer(1'b1, 8'h10, 32'h4);
      nWr = 0;
      wbXfer(1'b1, 8'h00, 32'h06);
      repeat (200) @(posedge clock);
      wbXfer(1'b1, 8'h00, 32'h08);
      chk(nWr > 40, 32'h1);
      $display("fifo done");
      // unlisted gate mode refused
      wbXfer(1'b1, 8'h04, 32'h0C);
      wbXfer(1'b1, 8'h00, 32'h05);
      wbXfer(1'b0, 8'h18, 32'h0);
      chk({rd[5], rd[2], acqBusy}, 32'h4);
      $display("refusal done");
      // external rising gate, one slow channel
      wbXfer(1'b1, 8'h04, 32'h0);
      wbXfer(1'b1, 8'h10, 32'h100);
      wbXfer(1'b1, 8'h14, 32'h8);
      nWr = 0;
      wbXfer(1'b1, 8'h00, 32'h05);
      gate(30);
      chk(nWr, 32'h18);
      chk(firstData[11:0], 12'(gateAt - 12'h00A));
      gate(20);
      chk(nWr, 32'h28);
      wbXfer(1'b1, 8'h00, 32'h08);
      // two slow channels, alignment of four
      wbXfer(1'b1, 8'h04, 32'h20);
      nWr = 0;
      wbXfer(1'b1, 8'h00, 32'h05);
      gate(30);
      chk(nWr, 32'h1C);
      $display("gated done");
      summarize();
   end
endmodule // tb_gsc_top
